// File: hdl/fetch_regs.svh
/*
  Constants of the instruction fetch and decode block: reset values,
  address step, opcode tags and field positions.
  Assumes it is included by its bare name from package and modules.
*/
`ifndef FETCH_REGS_SVH
`define FETCH_REGS_SVH

// program counter after reset, byte address
`define RESET_PC        21'h000000
// bytes taken by one instruction word
`define WORD_BYTES      21'h000002
// top nibble of any second word
`define SECOND_TAG      4'hf
`define TAG_MSB         15
`define TAG_LSB         12
// literal field of a second word
`define LIT_MSB         11
`define LIT_LSB         0
// first words of the two-word instructions
`define MOVE_FF_TAG     4'hc
`define JUMP_OPC        8'hef
`define CALL_OPC        7'h76
`define CALL_LSB        9
`define LOAD_PTR_OPC    10'h3b8
`define LOAD_PTR_LSB    6
// low target bits held in the first word of jump and call
`define TGT_LO_MSB      7

`endif

// File: hdl/fetch_pkg.sv
/*
  Types and helper functions of the instruction fetch and decode block.
  Assumes fetch_regs.svh is on the include path.
*/
`include "fetch_regs.svh"

package fetch_pkg;

  typedef logic [20:0] byte_addr_t;
  typedef logic [19:0] word_addr_t;
  typedef logic [15:0] instr_word_t;
  typedef logic [11:0] literal_t;
  typedef logic [10:0] branch_off_t;

  typedef enum logic [2:0] {
    st_fetch_first,
    st_wait_first,
    st_wait_second,
    st_issue
  } fetch_phase_t;

  typedef struct packed {
    fetch_phase_t phase;
    byte_addr_t   pc;
    instr_word_t  first_word;
    logic         skip_pending;
    logic         mem_rd;
    byte_addr_t   mem_addr;
    logic         exec_valid;
    instr_word_t  exec_word;
    literal_t     exec_literal;
    logic         exec_two_word;
    logic         exec_nop;
    byte_addr_t   exec_next_pc;
  } fetch_state_t;

  // true when the top nibble marks a second word
  function automatic logic is_tagged(input instr_word_t w);
    return w[`TAG_MSB:`TAG_LSB] == `SECOND_TAG;
  endfunction

endpackage

// File: hdl/class_if.sv
/*
  Carries one instruction word to the word classifier and its verdict
  back to the fetch sequencer.
  Assumes a purely combinational classifier.
*/
`timescale 1ns/1ps

interface class_if;
  logic [15:0] word;
  logic        is_orphan;
  logic        is_two_first;
  logic        is_jump;
  logic        is_call;

  modport classifier (
    input  word,
    output is_orphan,
    output is_two_first,
    output is_jump,
    output is_call
  );

  modport user (
    output word,
    input  is_orphan,
    input  is_two_first,
    input  is_jump,
    input  is_call
  );
endinterface

// File: hdl/word_classifier.sv
/*
  Combinational classifier of one instruction word: second-word tag,
  first word of a two-word instruction, jump and call opcodes.
  Assumes the word presented is a first-position word.
*/
`timescale 1ns/1ps
`include "fetch_regs.svh"

module word_classifier
  import fetch_pkg::*;
(
  class_if.classifier cls
);

  always_comb begin
    // a tagged word seen in first position runs alone
    cls.is_orphan    = is_tagged(cls.word);
    cls.is_jump      = cls.word[15:8] == `JUMP_OPC;
    cls.is_call      = cls.word[15:`CALL_LSB] == `CALL_OPC;
    // exactly four two-word kinds: call, move, jump, pointer load
    cls.is_two_first = cls.is_jump
                     | cls.is_call
                     | (cls.word[15:12] == `MOVE_FF_TAG)
                     | (cls.word[15:`LOAD_PTR_LSB] == `LOAD_PTR_OPC);
  end

endmodule // word_classifier

// File: hdl/program_memory_instruction_fetch.sv
/*
  Fetch and decode sequencer between byte-addressed program memory and
  the core execute stage. Reads one instruction word at a time,
  recognises the four two-word kinds, fetches their second word straight
  after the first, and issues each instruction with its literal and its
  return address. Jump and call load their absolute target; the execute
  stage may load, branch or skip in the issue cycle. Only mem_rd and
  exec_valid pulse; the other outputs hold until the next update.
  Assumes the memory shows the read word in the cycle in which mem_rd
  stands, and the execute stage answers skip, branch and load requests
  in the cycle in which exec_valid stands. A reset restarts fetching at
  byte address zero. The word classifier is purely combinational.
*/
//
// Overview of operation
// - memory addressed per byte; instructions are two or four bytes.
// - instruction low byte sits at an even byte address.
// - counter steps by two; bit zero always reads zero.
// - jump and call targets are word addresses loaded into pc 20..1.
// - branch offset counts single-word instructions, not bytes.
// - four two-word kinds: call, move, jump, pointer load.
// - second word tagged 1111 on top, twelve literal bits below.
// - second word fetched in sequence hands its literal to execute.
// - tagged word executed without first word runs as no-operation.
`timescale 1ns/1ps
`include "fetch_regs.svh"

module program_memory_instruction_fetch
  import fetch_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  output      logic                   mem_rd,
  output      fetch_pkg::byte_addr_t  mem_addr,
  input  wire fetch_pkg::instr_word_t mem_rdata,
  output      logic                   exec_valid,
  output      fetch_pkg::instr_word_t exec_word,
  output      fetch_pkg::literal_t    exec_literal,
  output      logic                   exec_two_word,
  output      logic                   exec_nop,
  output      fetch_pkg::byte_addr_t  exec_next_pc,
  input  wire logic                   skip_req,
  input  wire logic                   branch_req,
  input  wire fetch_pkg::branch_off_t branch_words,
  input  wire logic                   load_req,
  input  wire fetch_pkg::word_addr_t  load_word_addr
);
  import fetch_pkg::*;

  fetch_state_t s;
  fetch_state_t next_s;

  class_if cls ();

  word_classifier u_classifier (
    .cls (cls)
  );

  // next sequential word, bit zero forced low
  function automatic byte_addr_t step_pc(input byte_addr_t pc);
    byte_addr_t t;
    t = pc + `WORD_BYTES;
    return {t[20:1], 1'b0};
  endfunction

  // word address placed on pc 20..1
  function automatic byte_addr_t word_target(input word_addr_t w);
    return {w, 1'b0};
  endfunction

  // signed offset in instruction words
  function automatic byte_addr_t branch_target(input byte_addr_t pc,
                                               input branch_off_t off);
    word_addr_t ext;
    word_addr_t sum;
    ext = {{9{off[10]}}, off};
    sum = pc[20:1] + ext;
    return {sum, 1'b0};
  endfunction

  function automatic fetch_state_t reset_state();
    fetch_state_t r;
    r = '0;
    r.phase = st_fetch_first;
    r.pc    = `RESET_PC;
    return r;
  endfunction

  // put one read on the memory port, even byte address only
  function automatic fetch_state_t fetch_word(input fetch_state_t st,
                                              input byte_addr_t   a);
    fetch_state_t r;
    r          = st;
    r.mem_rd   = 1'b1;
    r.mem_addr = {a[20:1], 1'b0};
    return r;
  endfunction

  // issue a lone word; a tagged word here has lost its first word
  function automatic fetch_state_t issue_single(input fetch_state_t st,
                                                input instr_word_t  w,
                                                input logic         orphan);
    fetch_state_t r;
    r               = st;
    r.exec_valid    = 1'b1;
    r.exec_word     = w;
    r.exec_literal  = '0;
    r.exec_two_word = 1'b0;
    r.exec_nop      = orphan;
    r.pc            = step_pc(st.pc);
    r.exec_next_pc  = step_pc(st.pc);
    r.phase         = st_issue;
    return r;
  endfunction

  // issue a pair; its second word hands over the literal
  function automatic fetch_state_t issue_pair(input fetch_state_t st,
                                              input instr_word_t  w2);
    fetch_state_t r;
    r               = st;
    r.exec_valid    = 1'b1;
    r.exec_word     = st.first_word;
    r.exec_literal  = w2[`LIT_MSB:`LIT_LSB];
    r.exec_two_word = 1'b1;
    // an untagged second word voids the pair
    r.exec_nop      = !is_tagged(w2);
    r.pc            = step_pc(st.pc);
    r.exec_next_pc  = step_pc(st.pc);
    r.phase         = st_issue;
    return r;
  endfunction

  // absolute target of jump and call, as a word address
  function automatic byte_addr_t pair_target(input instr_word_t w1,
                                             input instr_word_t w2);
    return word_target({w2[`LIT_MSB:`LIT_LSB], w1[`TGT_LO_MSB:0]});
  endfunction

  // classify the first word, held or arriving
  always_comb begin
    if (s.phase == st_wait_second) begin
      cls.word = s.first_word;
    end else begin
      cls.word = mem_rdata;
    end
  end

  always_comb begin
    next_s            = s;
    next_s.mem_rd     = 1'b0;
    next_s.exec_valid = 1'b0;
    case (s.phase)
      st_fetch_first: begin
        next_s       = fetch_word(next_s, s.pc);
        next_s.phase = st_wait_first;
      end
      st_wait_first: begin
        if (s.skip_pending) begin
          // skipped word is dropped, one word only
          next_s.skip_pending = 1'b0;
          next_s.pc           = step_pc(s.pc);
          next_s.phase        = st_fetch_first;
        end else if (cls.is_two_first) begin
          // fetch second word straight after the first
          next_s.first_word = mem_rdata;
          next_s.pc         = step_pc(s.pc);
          next_s            = fetch_word(next_s, step_pc(s.pc));
          next_s.phase      = st_wait_second;
        end else begin
          next_s = issue_single(next_s, mem_rdata, cls.is_orphan);
        end
      end
      st_wait_second: begin
        next_s = issue_pair(next_s, mem_rdata);
        if (is_tagged(mem_rdata) && (cls.is_jump || cls.is_call)) begin
          next_s.pc = pair_target(s.first_word, mem_rdata);
        end
      end
      st_issue: begin
        // priority: load, then branch, then skip
        case ({load_req, branch_req})
          2'b10, 2'b11: begin
            next_s.pc = word_target(load_word_addr);
          end
          2'b01: begin
            // base is the address after the issued instruction
            next_s.pc = branch_target(s.exec_next_pc, branch_words);
          end
          default: begin
            next_s.pc = s.pc;
          end
        endcase
        // a skip over a first word leaves its second to run alone
        next_s.skip_pending = skip_req && !load_req && !branch_req;
        next_s.phase        = st_fetch_first;
      end
      default: begin
        next_s = reset_state();
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign mem_rd        = s.mem_rd;
  assign mem_addr      = s.mem_addr;
  assign exec_valid    = s.exec_valid;
  assign exec_word     = s.exec_word;
  assign exec_literal  = s.exec_literal;
  assign exec_two_word = s.exec_two_word;
  assign exec_nop      = s.exec_nop;
  assign exec_next_pc  = s.exec_next_pc;

endmodule // program_memory_instruction_fetch

// File: testbench/fetch_props.sv
/*
  Port checker of the fetch sequencer.
  Assumes it is bound to program_memory_instruction_fetch.
*/
`timescale 1ns/1ps

module fetch_props
  import fetch_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   rst_b,
  input wire logic                   mem_rd,
  input wire fetch_pkg::byte_addr_t  mem_addr,
  input wire fetch_pkg::instr_word_t mem_rdata,
  input wire logic                   exec_valid,
  input wire fetch_pkg::instr_word_t exec_word,
  input wire fetch_pkg::literal_t    exec_literal,
  input wire logic                   exec_two_word,
  input wire logic                   exec_nop,
  input wire fetch_pkg::byte_addr_t  exec_next_pc,
  input wire logic                   skip_req,
  input wire logic                   branch_req,
  input wire fetch_pkg::branch_off_t branch_words,
  input wire logic                   load_req,
  input wire fetch_pkg::word_addr_t  load_word_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] prev;
  logic        jc;
  assign jc = exec_word[15:8] == 8'hef || exec_word[15:9] == 7'h76;
  always_ff @(posedge ref_clk) prev <= mem_rdata;

  a_addr_even: assert property (mem_rd |-> !mem_addr[0])
    else $error("odd fetch address");
  a_single_step: assert property (exec_valid && !exec_two_word
    |-> exec_next_pc == $past(mem_addr) + 21'h2) else $error("bad step");
  a_pair_step: assert property (exec_valid && exec_two_word |->
    $past(mem_rd, 2) && exec_next_pc == $past(mem_addr, 2) + 21'h4)
    else $error("bad pair step");
  a_pair_literal: assert property (exec_valid && exec_two_word |->
    exec_nop == (prev[15:12] != 4'hf) && (exec_nop ||
    exec_literal == prev[11:0])) else $error("bad literal");
  a_orphan_nop: assert property (exec_valid && !exec_two_word &&
    prev[15:12] == 4'hf |-> exec_nop) else $error("orphan not nop");
  a_jump_target: assert property (exec_valid && exec_two_word && jc &&
    !exec_nop && !load_req && !branch_req |-> ##2 mem_rd &&
    mem_addr == {exec_literal, exec_word[7:0], 1'b0}) else $error("bad jump");
  a_load_target: assert property (exec_valid && load_req |-> ##2
    mem_rd && mem_addr == {$past(load_word_addr, 2), 1'b0})
    else $error("bad load");
  a_branch_words: assert property (exec_valid && branch_req && !load_req
    |-> ##2 mem_rd && mem_addr == exec_next_pc +
    {{9{$past(branch_words[10], 2)}}, $past(branch_words, 2), 1'b0})
    else $error("bad branch");
endmodule // fetch_props

bind program_memory_instruction_fetch fetch_props chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .mem_rd(mem_rd), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .exec_valid(exec_valid), .exec_word(exec_word),
  .exec_literal(exec_literal), .exec_two_word(exec_two_word),
  .exec_nop(exec_nop), .exec_next_pc(exec_next_pc), .skip_req(skip_req),
  .branch_req(branch_req), .branch_words(branch_words),
  .load_req(load_req), .load_word_addr(load_word_addr));

// File: testbench/prog_mem_model.sv
/*
  Program memory model: one word per even byte address, read word shown
  in the cycle in which the request stands. Assumes the bench fills the
  array.
*/
`timescale 1ns/1ps

module prog_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_rd,
  input  wire logic [20:0] mem_addr,
  output      logic [15:0] mem_rdata
);
  logic [15:0] m [0:15];
  logic [15:0] last = 16'h0000;
  always @(posedge ref_clk) begin
    if (mem_rd) last <= m[mem_addr[4:1]];
  end
  // word stands while mem_rd does; idle bus shows the inverse of the last
  assign mem_rdata = mem_rd ? m[mem_addr[4:1]] : ~last;
endmodule // prog_mem_model

// File: testbench/test_program_memory_instruction_fetch.sv
/*
  Bench of the fetch sequencer: runs a short program through every
  two-word kind, skip, jump, call, load and branch, then resets mid-run.
  Assumes the memory model and checker compile first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t got %h", $time, a); end end

module test_program_memory_instruction_fetch;
  import fetch_pkg::*;
  logic        ref_clk, rst_b, mem_rd, exec_valid, exec_two_word, exec_nop;
  logic        skip_req, branch_req, load_req;
  byte_addr_t  mem_addr, exec_next_pc;
  instr_word_t mem_rdata, exec_word;
  literal_t    exec_literal;
  branch_off_t branch_words;
  word_addr_t  load_word_addr;
  int          n_errors, n_compared;
  // word, two-word at bit 9, nop at bit 8, low byte of next address
  logic [31:0] e [0:10] = '{32'h0e55_0002, 32'hc123_0206, 32'h6600_0008,
    32'hf456_010c, 32'hef0a_0210, 32'hed07_0218, 32'hf000_0110,
    32'hc123_0314, 32'hf000_0118, 32'hee05_021c, 32'h0e55_0002};
  logic [15:0] p [0:13] = '{16'h0e55, 16'hc123, 16'hf456, 16'h6600,
    16'hc123, 16'hf456, 16'hef0a, 16'hf000, 16'hc123, 16'h2400,
    16'hed07, 16'hf000, 16'hee05, 16'hf123};
  // literal handed over with each issue
  logic [11:0] q [0:10] = '{12'h000, 12'h456, 12'h000, 12'h000, 12'h000,
    12'h000, 12'h000, 12'h400, 12'h000, 12'h123, 12'h000};

  program_memory_instruction_fetch dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .exec_valid(exec_valid), .exec_word(exec_word),
    .exec_literal(exec_literal), .exec_two_word(exec_two_word),
    .exec_nop(exec_nop), .exec_next_pc(exec_next_pc), .skip_req(skip_req),
    .branch_req(branch_req), .branch_words(branch_words),
    .load_req(load_req), .load_word_addr(load_word_addr));
  prog_mem_model mem_u (.ref_clk(ref_clk), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task sc_reset;
    rst_b = 1'b0;
    repeat (8) @(negedge ref_clk);
    `CHK({mem_rd, exec_valid, mem_addr}, 23'h0)
    rst_b = 1'b1;
    @(negedge ref_clk);
    `CHK({mem_rd, mem_addr}, 22'h200000)
  endtask

  task issue(input int i, input logic s, input logic b, input logic l);
    int          k;
    logic [31:0] got;
    k = 0;
    while (exec_valid !== 1'b1 && k < 12) begin
      @(negedge ref_clk);
      k++;
    end
    if (exec_valid !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t no issue", $time);
      give_verdict;
    end else begin
      got = {exec_word, 6'h0, exec_two_word, exec_nop, exec_next_pc[7:0]};
      `CHK(got, e[i])
      `CHK(exec_literal, q[i])
      {skip_req, branch_req, load_req} = {s, b, l};
      @(negedge ref_clk);
      {skip_req, branch_req, load_req} = 3'b000;
    end
  endtask

  // skip, then load beating branch and skip, then backward branch
  task sc_program;
    for (int i = 0; i < 11; i++) begin
      issue(i, i == 2 || i == 7, i == 7 || i == 9, i == 7);
    end
  endtask

  initial begin
    {skip_req, branch_req, load_req} = 3'b000;
    branch_words = 11'h7f2;
    load_word_addr = 20'h0000b;
    for (int i = 0; i < 14; i++) mem_u.m[i] = p[i];
    sc_reset;
    sc_program;
    repeat (2) @(negedge ref_clk);
    sc_reset;
    issue(0, 1'b0, 1'b0, 1'b0);
    give_verdict;
  end
endmodule // test_program_memory_instruction_fetch
